//--- design/cgc_pkg.sv
package cgc_pkg;
  localparam logic [15:0] CGC_SYS_CLK_CTRL_ADDR = 16'hff3a;
  localparam logic [15:0] CGC_LOW_PWR_CTRL_ADDR = 16'hff44;
  localparam logic [7:0]  CGC_SYS_CLK_CTRL_RST  = 8'h00;
  localparam logic [7:0]  CGC_LOW_PWR_CTRL_RST  = 8'h00;
  localparam logic [7:0]  CGC_SYS_CLK_CTRL_MASK = 8'hc7;
  localparam int          CGC_PIN_OFF_BIT       = 7;
  localparam int          CGC_DIV_SEL_LSB       = 0;
  localparam int          CGC_DIV_SEL_W         = 3;
  localparam int          CGC_FB_BYPASS_BIT     = 5;
  localparam int          CGC_DIV_W             = 5;
  localparam int          CGC_DUTY_MIN_KHZ      = 5000;
  localparam int          CGC_OSC_KHZ           = 10000;
  localparam logic [2:0]  CGC_DIV_MAX_CODE      = 3'h5;
endpackage

//--- design/cgc_clock_gen_control.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cgc_clock_gen_control
  import cgc_pkg::*;
#(
  parameter int OSC_KHZ = CGC_OSC_KHZ
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        sleep_in,
  input  wire logic        sw_standby_in,
  input  wire logic        hw_standby_in,
  output logic      [7:0]  rdata_out,
  output logic             sys_clk_pin_out,
  output logic             sys_clk_pin_oe_out,
  output logic             bus_clk_en_out,
  output logic      [2:0]  bus_div_active_out,
  output logic             fb_bypass_out,
  output logic             duty_adj_on_out
);

  logic [7:0]           sys_clk_ctrl_q;
  logic [7:0]           low_pwr_ctrl_q;
  logic [2:0]           sw_sync_q;
  logic [2:0]           hw_sync_q;
  logic                 sw_stby_q;
  logic                 hw_stby_q;
  logic                 sw_stby_prev_q;
  logic [CGC_DIV_W-1:0] div_cnt_q;
  logic [2:0]           div_active_q;
  logic                 tick_d;
  logic                 phase_q;
  logic [CGC_DIV_W-1:0] div_mask;
  logic                 sys_clk_hit;
  logic                 low_pwr_hit;
  logic [2:0]           sel_req;
  logic                 sel_legal;
  logic                 sel_switch;

  // Oscillator fast enough for duty adjustment
  localparam logic DUTY_ADJ_OK = OSC_KHZ >= CGC_DUTY_MIN_KHZ;

  // Register address decode
  always_comb
  begin
    sys_clk_hit = addr_in == CGC_SYS_CLK_CTRL_ADDR;
    low_pwr_hit = addr_in == CGC_LOW_PWR_CTRL_ADDR;
  end

  // Pin inputs, three stages, change taken when last two agree
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sw_sync_q <= 3'h0;
      hw_sync_q <= 3'h0;
      sw_stby_q <= 1'b0;
      hw_stby_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sw_sync_q <= {sw_sync_q[1:0], sw_standby_in};
      hw_sync_q <= {hw_sync_q[1:0], hw_standby_in};
      if (sw_sync_q[2] == sw_sync_q[1])
        sw_stby_q <= sw_sync_q[2];
      if (hw_sync_q[2] == hw_sync_q[1])
        hw_stby_q <= hw_sync_q[2];
    end
  end

  // System clock control register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      sys_clk_ctrl_q <= CGC_SYS_CLK_CTRL_RST;
    else if (clk_en_in)
    begin
      if (hw_stby_q)
        sys_clk_ctrl_q <= CGC_SYS_CLK_CTRL_RST;
      else if (wr_in && sys_clk_hit)
        sys_clk_ctrl_q <= wdata_in & CGC_SYS_CLK_CTRL_MASK;
    end
  end

  // Low power control register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      low_pwr_ctrl_q <= CGC_LOW_PWR_CTRL_RST;
    else if (clk_en_in)
    begin
      if (hw_stby_q)
        low_pwr_ctrl_q <= CGC_LOW_PWR_CTRL_RST;
      else if (wr_in && low_pwr_hit)
        low_pwr_ctrl_q <= wdata_in;
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (clk_en_in)
    begin
      if (rd_in && sys_clk_hit)
        rdata_out <= sys_clk_ctrl_q;
      else if (rd_in && low_pwr_hit)
        rdata_out <= low_pwr_ctrl_q;
      else
        rdata_out <= 8'h00;
    end
  end

  // Oscillator bypass applied on software standby entry
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sw_stby_prev_q <= 1'b0;
      fb_bypass_out  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sw_stby_prev_q <= sw_stby_q;
      if (hw_stby_q)
        fb_bypass_out <= 1'b0;
      else if (sw_stby_q && !sw_stby_prev_q)
        fb_bypass_out <= low_pwr_ctrl_q[CGC_FB_BYPASS_BIT];
    end
  end

  // Duty adjustment enable
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      duty_adj_on_out <= DUTY_ADJ_OK;
    else if (clk_en_in)
      duty_adj_on_out <= !fb_bypass_out && DUTY_ADJ_OK;
  end

  // Free-running medium-speed divider
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      div_cnt_q <= '0;
    else if (clk_en_in)
      div_cnt_q <= div_cnt_q + 1'b1;
  end

  always_comb
  begin
    div_mask = CGC_DIV_W'((1 << div_active_q) - 1);
    tick_d   = (div_cnt_q & div_mask) == div_mask;
  end

  // Requested selection, switched only where every period ends
  always_comb
  begin
    sel_req    = sys_clk_ctrl_q[CGC_DIV_SEL_LSB +: CGC_DIV_SEL_W];
    sel_legal  = sel_req <= CGC_DIV_MAX_CODE;
    sel_switch = tick_d && (div_cnt_q == {CGC_DIV_W{1'b1}});
  end

  // Selection switches only at a common period boundary
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      div_active_q <= 3'h0;
    else if (clk_en_in && sel_switch && sel_legal)
      div_active_q <= sel_req;
  end

  // Bus master clock enable and active selection
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bus_clk_en_out     <= 1'b0;
      bus_div_active_out <= 3'h0;
    end
    else if (clk_en_in)
    begin
      bus_clk_en_out     <= tick_d;
      bus_div_active_out <= div_active_q;
    end
  end

  // System clock output pin
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q            <= 1'b0;
      sys_clk_pin_out    <= 1'b1;
      sys_clk_pin_oe_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      phase_q            <= ~phase_q;
      sys_clk_pin_oe_out <= !hw_stby_q;
      if (hw_stby_q || sw_stby_q || sleep_in || sys_clk_ctrl_q[CGC_PIN_OFF_BIT])
        sys_clk_pin_out <= 1'b1;
      else
        sys_clk_pin_out <= phase_q;
    end
  end

endmodule
`default_nettype wire

//--- verification/cgc_props_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cgc_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        clk_en_in,
  input wire logic [15:0] addr_in,
  input wire logic        rd_in,
  input wire logic        sleep_in,
  input wire logic        sw_standby_in,
  input wire logic        hw_standby_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        sys_clk_pin_out,
  input wire logic        sys_clk_pin_oe_out,
  input wire logic        bus_clk_en_out,
  input wire logic [2:0]  bus_div_active_out,
  input wire logic        fb_bypass_out,
  input wire logic        duty_adj_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_resv_zero:
  assert property ($past(rd_in && clk_en_in && addr_in == 16'hff3a) |-> rdata_out[5:3] == 3'h0) else $error("bad bits");
  a_hw_float:
  assert property (hw_standby_in [*6] |-> !sys_clk_pin_oe_out) else $error("pin driven");
  a_sleep_high:
  assert property (sleep_in [*2] |-> sys_clk_pin_out) else $error("pin low in sleep");
  a_full_speed:
  assert property (bus_div_active_out == 3'h0 ##1 bus_div_active_out == 3'h0 |-> bus_clk_en_out) else $error("tick lost");
  a_div_legal:
  assert property (bus_div_active_out <= 3'h5) else $error("bad divider");
  a_duty_off:
  assert property (fb_bypass_out ##1 fb_bypass_out |-> !duty_adj_on_out) else $error("duty on");
  a_bypass_hold:
  assert property (!sw_standby_in [*6] |-> !$rose(fb_bypass_out)) else $error("early bypass");
  a_no_short:
  assert property (bus_clk_en_out && bus_div_active_out != 3'h0 && clk_en_in |=> bus_div_active_out == 3'h0 || !bus_clk_en_out)
    else $error("short pulse");
endmodule
bind cgc_clock_gen_control cgc_props i_cgc_props (.*);
`default_nettype wire

//--- verification/cgc_bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module cgc_bus_master_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        bus_clk_en_in,
  output logic      [15:0] ticks_out
);
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      ticks_out <= 16'h0000;
    else if (bus_clk_en_in)
      ticks_out <= ticks_out + 16'h0001;
endmodule
`default_nettype wire

//--- verification/clock_gen_control_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module clock_gen_control_regs_tb_top;
  logic clk = 0, rst = 1, cen = 1, wr_s = 0, rd_s = 0, slp = 0, sws = 0, hws = 0, pin, oe, en, byp, duty;
  logic [15:0] addr = 0, ticks, t0;
  logic [7:0] wd = 0, rdat;
  logic [2:0] div;
  int fails = 0, n_compared = 0, cyc = 0;
  always #50 clk = ~clk;
  cgc_clock_gen_control i_cgc_clock_gen_control (.clk_in(clk), .rst_in(rst), .clk_en_in(cen), .addr_in(addr),
    .wdata_in(wd), .wr_in(wr_s), .rd_in(rd_s), .sleep_in(slp), .sw_standby_in(sws), .hw_standby_in(hws),
    .rdata_out(rdat), .sys_clk_pin_out(pin), .sys_clk_pin_oe_out(oe), .bus_clk_en_out(en),
    .bus_div_active_out(div), .fb_bypass_out(byp), .duty_adj_on_out(duty));
  cgc_bus_master_model i_cgc_bus_master_model (.clk_in(clk), .rst_in(rst), .bus_clk_en_in(en), .ticks_out(ticks));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdat, e);
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(16'hff3a, 8'h00);
    rd(16'hff44, 8'h00);
    @(negedge clk);
    chk({7'h0, duty}, 8'h01);
    @(posedge clk);
    wr(16'hff3a, 8'h85);
    rd(16'hff3a, 8'h85);
    wr(16'hff3a, 8'h38);
    rd(16'hff3a, 8'h00);
    wr(16'hff44, 8'hdf);
    rd(16'hff44, 8'hdf);
    cen <= 1'b0;
    wr(16'hff44, 8'h11);
    cen <= 1'b1;
    rd(16'hff44, 8'hdf);
    rd(16'hff40, 8'h00);
    $display("register test done");
    for (int c = 0; c < 6; c++)
    begin
      wr(16'hff3a, 8'(c));
      repeat (70) @(negedge clk);
      chk({5'h0, div}, 8'(c));
      t0 = ticks;
      repeat (64) @(negedge clk);
      chk(8'(ticks - t0), 8'(64 >> c));
      @(posedge clk);
    end
    $display("divider test done");
    wr(16'hff3a, 8'h00);
    repeat (3) @(negedge clk);
    t0 = {15'h0, pin};
    @(negedge clk);
    chk({7'h0, pin}, {7'h0, ~t0[0]});
    @(posedge clk);
    slp <= 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, pin}, 8'h01);
    @(posedge clk);
    slp <= 1'b0;
    wr(16'hff3a, 8'h80);
    repeat (3) @(negedge clk);
    chk({7'h0, pin}, 8'h01);
    @(negedge clk);
    chk({7'h0, pin}, 8'h01);
    @(posedge clk);
    $display("pin test done");
    wr(16'hff44, 8'h20);
    repeat (8) @(negedge clk);
    chk({7'h0, byp}, 8'h00);
    @(posedge clk);
    wr(16'hff3a, 8'h05);
    sws <= 1'b1;
    repeat (8) @(posedge clk);
    sws <= 1'b0;
    @(negedge clk);
    chk({6'h0, byp, duty}, 8'h02);
    chk({7'h0, pin}, 8'h01);
    @(posedge clk);
    rd(16'hff44, 8'h20);
    rd(16'hff3a, 8'h05);
    hws <= 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h0, oe, byp}, 8'h00);
    @(posedge clk);
    hws <= 1'b0;
    repeat (6) @(posedge clk);
    rd(16'hff3a, 8'h00);
    rd(16'hff44, 8'h00);
    $display("standby test done");
    test_done();
  end
endmodule
`default_nettype wire
